// ==== core/tcc_timer.sv ====
// timer configuration, clock selection, prescaler and main counter.
// assumes a single 250 MHz clock; the counter clock, external clock,
// trigger and low-power mode levels arrive asynchronously as pins.
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "tcc_params.svh"

module tcc_timer
	import tcc_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic counter_clock_pin,
	input wire logic ext_clock_pin,
	input wire logic trigger_pin,
	input wire logic debug_mode_pin,
	input wire logic doze_mode_pin,
	input wire logic [15:0] global_timebase_in,
	output logic [15:0] channel_timebase,
	output logic count_step,
	output logic overflow_flag,
	output logic overflow_pulse
);

	// byte-lane mask from the byte enables
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// merge write data into an old word under the byte enables
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		merge = (old_v & ~lane_mask(be)) | (new_v & lane_mask(be));
	endfunction

	tcc_cfg_t cfg_q; // bus-side configuration registers
	logic [15:0] mod_q; // modulo_value
	logic ack_q; // one-cycle answer marker for the bus
	logic [31:0] rdata_q; // registered read data
	tcc_cfg_t cfg_s1_q; // config crossing, first stage
	tcc_cfg_t cfg_s2_q; // config crossing, the only stage counting reads
	tcc_pins_t pin_s1_q; // pin synchroniser, first stage
	tcc_pins_t pin_s2_q; // pin synchroniser, second stage
	logic cnt_clk_prev_q; // previous synced levels for edge detection
	logic ext_clk_prev_q;
	logic trig_prev_q;
	logic ext_pend_q; // external edge waiting for the next counter clock edge
	logic [`TCC_PRE_W-1:0] pre_q; // prescaler
	logic [`TCC_CNT_W-1:0] cnt_q; // main counter
	tcc_state_t state_q; // counting sequence state
	logic flag_q; // sticky overflow flag
	logic ovf_pulse_q; // one-cycle overflow pulse
	logic [15:0] tb_q; // channel timebase
	logic step_q; // registered count step

	// decoded bus strokes
	logic req;
	logic wr_go;
	logic rd_go;
	logic [31:0] cfg_word;
	logic [31:0] sc_word;
	logic [31:0] st_word;
	logic [31:0] wr_cfg;
	logic [31:0] wr_sc;
	logic [31:0] wr_mod;
	// counting-side events
	logic cnt_edge;
	logic ext_edge;
	logic tick;
	logic paused;
	logic trig_rise;
	logic [`TCC_PRE_W-1:0] ps_mask;
	logic pre_out;
	logic enabled;
	logic cnt_clear;
	logic at_mod;
	logic ovf_evt;
	logic flag_clr;

	// one wait cycle; writes land on the answering edge, reads capture early
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_go = avs_write & ack_q;
	assign rd_go = avs_read & ~ack_q;

	// answer marker toggles so back-to-back requests each wait once
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	// readable images; reserved bits stay zero
	always_comb
	begin
		cfg_word = 32'h0000_0000;
		cfg_word[`TCC_CFG_SOO_BIT] = cfg_q.stop_on_overflow;
		cfg_word[`TCC_CFG_SOT_BIT] = cfg_q.start_on_trigger;
		cfg_word[`TCC_CFG_GTB_BIT] = cfg_q.global_timebase_en;
		cfg_word[`TCC_CFG_DBG_HI:`TCC_CFG_DBG_LO] = cfg_q.debug_behaviour;
		cfg_word[`TCC_CFG_DOZE_BIT] = cfg_q.doze_pause_en;
		sc_word = 32'h0000_0000;
		sc_word[`TCC_SC_FLAG_BIT] = flag_q;
		// the counting side's copy, so a disable reads zero only once seen
		sc_word[`TCC_SC_CS_HI:`TCC_SC_CS_LO] = cfg_s2_q.counter_clock_sel;
		sc_word[`TCC_SC_PS_HI:`TCC_SC_PS_LO] = cfg_q.prescale_sel;
		st_word = 32'h0000_0000;
		st_word[0] = (state_q == TCC_ST_WAIT_TRIG);
		st_word[1] = (state_q == TCC_ST_HALTED);
		st_word[2] = (state_q == TCC_ST_RUN);
		st_word[3] = paused;
	end

	// write images with byte enables applied
	assign wr_cfg = merge(cfg_word, avs_writedata, avs_byteenable);
	assign wr_sc = merge(sc_word, avs_writedata, avs_byteenable);
	assign wr_mod = merge({16'h0000, mod_q}, avs_writedata, avs_byteenable);

	// read data captured in the waiting cycle, unmapped reads give zero
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= 32'h0000_0000;
		else if (rd_go)
		begin
			unique case (avs_address)
				`TCC_OFS_CONFIG: rdata_q <= cfg_word;
				`TCC_OFS_STATUS_CONTROL: rdata_q <= sc_word;
				`TCC_OFS_MODULO: rdata_q <= {16'h0000, mod_q};
				`TCC_OFS_COUNT: rdata_q <= {16'h0000, cnt_q};
				`TCC_OFS_STATE: rdata_q <= st_word;
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign avs_readdata = rdata_q;

	// configuration register writes; software is expected to change
	// start-on-trigger only while disabled, nothing here enforces it
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_q <= '0;
		end
		else if (wr_go && avs_address == `TCC_OFS_CONFIG)
		begin
			cfg_q.stop_on_overflow <= wr_cfg[`TCC_CFG_SOO_BIT];
			cfg_q.start_on_trigger <= wr_cfg[`TCC_CFG_SOT_BIT];
			cfg_q.global_timebase_en <= wr_cfg[`TCC_CFG_GTB_BIT];
			cfg_q.debug_behaviour <= wr_cfg[`TCC_CFG_DBG_HI:`TCC_CFG_DBG_LO];
			cfg_q.doze_pause_en <= wr_cfg[`TCC_CFG_DOZE_BIT];
		end
		else if (wr_go && avs_address == `TCC_OFS_STATUS_CONTROL)
		begin
			// writable at any time; zero stops counting, clears the prescaler and returns the sequence to idle
			cfg_q.counter_clock_sel <= tcc_clk_sel_t'(wr_sc[`TCC_SC_CS_HI:`TCC_SC_CS_LO]);
			cfg_q.prescale_sel <= wr_sc[`TCC_SC_PS_HI:`TCC_SC_PS_LO];
		end
	end

	// modulo value register
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			mod_q <= `TCC_MOD_RESET;
		else if (wr_go && avs_address == `TCC_OFS_MODULO)
			mod_q <= wr_mod[15:0];
	end

	// configuration crosses two stages before counting sees it
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_s1_q <= '0;
			cfg_s2_q <= '0;
		end
		else
		begin
			cfg_s1_q <= cfg_q;
			cfg_s2_q <= cfg_s1_q;
		end
	end

	// two-flop synchronisers on every asynchronous pin; only the second
	// stage is read, and its previous level feeds the edge detectors
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			cnt_clk_prev_q <= 1'b0;
			ext_clk_prev_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end
		else
		begin
			pin_s1_q <= {counter_clock_pin, ext_clock_pin, trigger_pin,
				debug_mode_pin, doze_mode_pin};
			pin_s2_q <= pin_s1_q;
			cnt_clk_prev_q <= pin_s2_q.cnt_clk;
			ext_clk_prev_q <= pin_s2_q.ext_clk;
			trig_prev_q <= pin_s2_q.trigger;
		end
	end

	// the shared counter clock paces everything; one pin for all
	// instances keeps external timebases aligned
	assign cnt_edge = pin_s2_q.cnt_clk & ~cnt_clk_prev_q;
	assign ext_edge = pin_s2_q.ext_clk & ~ext_clk_prev_q;

	// an external edge is held until the next counter clock edge, so
	// external ticks land on counter clock edges; it must run below
	// half the counter clock or edges merge
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			ext_pend_q <= 1'b0;
		else if (ext_edge)
			ext_pend_q <= 1'b1;
		else if (cnt_edge)
			ext_pend_q <= 1'b0;
	end

	// selected clock source; reserved select code counts nothing
	always_comb
	begin
		unique case (cfg_s2_q.counter_clock_sel)
			TCC_CS_CNTCLK: tick = cnt_edge;
			TCC_CS_EXTCLK: tick = cnt_edge & ext_pend_q;
			TCC_CS_OFF: tick = 1'b0;
			TCC_CS_RSVD: tick = 1'b0;
		endcase
	end

	// pause in debug when behaviour code is 00, in doze when enabled
	assign paused = (pin_s2_q.debug_mode &&
		cfg_s2_q.debug_behaviour == `TCC_DBG_PAUSE) ||
		(pin_s2_q.doze_mode && cfg_s2_q.doze_pause_en);

	// triggers are blind while paused
	assign trig_rise = pin_s2_q.trigger & ~trig_prev_q & ~paused;

	assign enabled = cfg_s2_q.counter_clock_sel inside {TCC_CS_CNTCLK, TCC_CS_EXTCLK};

	// divide by two to the select value: 1 up to 128
	assign ps_mask = `TCC_PRE_W'((8'h01 << cfg_s2_q.prescale_sel) - 8'h01);
	assign pre_out = tick && ((pre_q & ps_mask) == ps_mask) && !paused;

	// seven-bit prescaler, cleared when disabled, else frozen while paused or not running
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			pre_q <= '0;
		else if (!enabled)
			pre_q <= '0;
		else if (tick && !paused && state_q == TCC_ST_RUN)
			pre_q <= pre_q + `TCC_PRE_W'(1);
	end

	// sequencing of enable, trigger start and overflow halt
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			state_q <= TCC_ST_IDLE;
		else if (!enabled)
			state_q <= TCC_ST_IDLE;
		else
		begin
			unique case (state_q)
				TCC_ST_IDLE:
					if (cfg_s2_q.start_on_trigger)
						state_q <= TCC_ST_WAIT_TRIG;
					else
						state_q <= TCC_ST_RUN;
				TCC_ST_WAIT_TRIG:
					if (trig_rise)
						state_q <= TCC_ST_RUN;
				TCC_ST_RUN:
					if (ovf_evt && cfg_s2_q.stop_on_overflow)
						state_q <= TCC_ST_HALTED;
				// only a trigger with start-on-trigger, or re-enable, wakes it
				TCC_ST_HALTED:
					if (trig_rise && cfg_s2_q.start_on_trigger)
						state_q <= TCC_ST_RUN;
			endcase
		end
	end

	// a count step happens only on prescaler output while running
	assign at_mod = (cnt_q == mod_q);
	assign ovf_evt = pre_out && state_q == TCC_ST_RUN && at_mod;
	assign cnt_clear = wr_go && avs_address == `TCC_OFS_COUNT;

	// sixteen-bit main counter; disabling leaves the value alone
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			cnt_q <= `TCC_CNT_RESET;
		else if (cnt_clear)
			cnt_q <= `TCC_CNT_RESET; // any write clears, does not halt
		else if (pre_out && state_q == TCC_ST_RUN)
		begin
			if (at_mod)
				cnt_q <= `TCC_CNT_RESET;
			else
				cnt_q <= cnt_q + `TCC_CNT_W'(1);
		end
	end

	// overflow flag: write one to clear, a new overflow wins
	assign flag_clr = wr_go && avs_address == `TCC_OFS_STATUS_CONTROL &&
		avs_byteenable[0] && avs_writedata[`TCC_SC_FLAG_BIT];

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			flag_q <= 1'b0;
		else if (ovf_evt)
			flag_q <= 1'b1;
		else if (flag_clr)
			flag_q <= 1'b0;
	end

	// overflow pulse, the request source for interrupt or dma logic, and
	// the count enable for the channel logic, both already in bus timing
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			ovf_pulse_q <= 1'b0;
			step_q <= 1'b0;
		end
		else
		begin
			ovf_pulse_q <= ovf_evt;
			step_q <= pre_out && state_q == TCC_ST_RUN;
		end
	end

	// channel timebase: external when global mode is on
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			tb_q <= 16'h0000;
		else if (cfg_s2_q.global_timebase_en)
			tb_q <= global_timebase_in;
		else
			tb_q <= cnt_q;
	end

	assign channel_timebase = tb_q;
	assign count_step = step_q;
	assign overflow_flag = flag_q;
	assign overflow_pulse = ovf_pulse_q;

endmodule

// ==== inc/tcc_params.svh ====
// constants for the timer configuration and clocking block.
// assumes byte addressing on the register bus, one aligned word per register.
//
// Operation
// - start-on-trigger holds enabled counter until trigger rises
// - trigger edge restarts counter halted on overflow, only with start-on-trigger set
// - without start-on-trigger, enabling starts counting at once
// - triggers ignored while paused in debug or doze
// - global timebase enable selects external channel timebase
// - timebase enable clear selects internal counter timebase
// - debug code 00 pauses everything, 11 keeps running
// - doze pause enable pauses counter and triggers
// - reserved configuration bits read zero, ignore writes
// - register interface and requests live in bus domain
// - counter and prescaler run on the counter clock
// - all instances share one common counter clock
// - clock select resets to zero, counter disabled
// - clock select reads back only after counter acknowledges
// - external clock synchronised to counter clock edges
// - seven-bit prescaler gates every main counter step
// - main counter is sixteen bits wide
// - stop-on-overflow halts at modulo and sets flag
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// register byte offsets
`define TCC_OFS_CONFIG 5'h00
`define TCC_OFS_STATUS_CONTROL 5'h04
`define TCC_OFS_MODULO 5'h08
`define TCC_OFS_COUNT 5'h0C
`define TCC_OFS_STATE 5'h10

// timer_config fields
`define TCC_CFG_SOO_BIT 17
`define TCC_CFG_SOT_BIT 16
`define TCC_CFG_GTB_BIT 9
`define TCC_CFG_DBG_HI 7
`define TCC_CFG_DBG_LO 6
`define TCC_CFG_DOZE_BIT 5

// timer_status_control fields
`define TCC_SC_FLAG_BIT 7
`define TCC_SC_CS_HI 4
`define TCC_SC_CS_LO 3
`define TCC_SC_PS_HI 2
`define TCC_SC_PS_LO 0

// debug behaviour codes
`define TCC_DBG_PAUSE 2'h0

// sizes and reset values
`define TCC_CNT_W 16
`define TCC_PRE_W 7
`define TCC_MOD_RESET 16'hFFFF
`define TCC_CNT_RESET 16'h0000

`endif

// ==== inc/tcc_pkg.sv ====
// types shared by the timer configuration and clocking block.
// assumes tcc_params.svh is on the include path.
`include "tcc_params.svh"

package tcc_pkg;

	// counter clock select codes
	typedef enum logic [1:0] {
		TCC_CS_OFF,
		TCC_CS_CNTCLK,
		TCC_CS_EXTCLK,
		TCC_CS_RSVD
	} tcc_clk_sel_t;

	// counter sequencing states
	typedef enum logic [1:0] {
		TCC_ST_IDLE,
		TCC_ST_WAIT_TRIG,
		TCC_ST_RUN,
		TCC_ST_HALTED
	} tcc_state_t;

	// configuration as it travels to the counting logic
	typedef struct packed {
		logic start_on_trigger;
		logic stop_on_overflow;
		logic global_timebase_en;
		logic [1:0] debug_behaviour;
		logic doze_pause_en;
		tcc_clk_sel_t counter_clock_sel;
		logic [2:0] prescale_sel;
	} tcc_cfg_t;

	// raw pins after synchronisation
	typedef struct packed {
		logic cnt_clk;
		logic ext_clk;
		logic trigger;
		logic debug_mode;
		logic doze_mode;
	} tcc_pins_t;

endpackage

// ==== testbench/tcc_timer_assertions.sv ====
// checker for the timer block, watching only the ports of tcc_timer.
// assumes the one-wait-cycle bus and the two-clock settings delay.
`timescale 1ns/1ps

module tcc_timer_checker
	import tcc_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic counter_clock_pin,
	input wire logic ext_clock_pin,
	input wire logic trigger_pin,
	input wire logic debug_mode_pin,
	input wire logic doze_mode_pin,
	input wire logic [15:0] global_timebase_in,
	input wire logic [15:0] channel_timebase,
	input wire logic count_step,
	input wire logic overflow_flag,
	input wire logic overflow_pulse
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	wire wr_ok = avs_write && !avs_waitrequest; // write taken
	wire rd_ok = avs_read && !avs_waitrequest; // read taken
	logic [3:0] since_q; // cycles since a taken write, saturating
	logic [3:0] pause_q; // cycles the pause has held, saturating
	logic gtb_q; // timebase select as last written
	logic [2:0] dbg_q; // debug code and doze pause enable
	logic [1:0] cs_q; // clock select as last written
	// pause: debug code 00 with debug mode, or doze with pause enabled
	wire pause_c = (debug_mode_pin && dbg_q[2:1] == 2'h0) || (doze_mode_pin && dbg_q[0]);

	// shadow of the settings, so outputs can be tied to them
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			gtb_q <= 1'b0;
			dbg_q <= 3'h0;
			cs_q <= 2'h0;
		end
		else if (wr_ok)
		begin
			if (avs_address == 5'h00 && avs_byteenable[1])
				gtb_q <= avs_writedata[9];
			if (avs_address == 5'h00 && avs_byteenable[0])
				dbg_q <= avs_writedata[7:5];
			if (avs_address == 5'h04 && avs_byteenable[0])
				cs_q <= avs_writedata[4:3];
		end
	end

	// settings need a few clocks to pass the synchronisers, so wait them out
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			since_q <= 4'h0;
		else if (wr_ok)
			since_q <= 4'h0;
		else if (since_q != 4'hF)
			since_q <= since_q + 4'h1;
	end

	// steps already in the pipeline may still land early in a pause
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			pause_q <= 4'h0;
		else if (!pause_c || wr_ok)
			pause_q <= 4'h0;
		else if (pause_q != 4'hF)
			pause_q <= pause_q + 4'h1;
	end

	sequence req_start;
		$rose(avs_read) || $rose(avs_write);
	endsequence
	sequence one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence

	wait_once_a: assert property (req_start |-> one_wait)
		else $error("bus request not answered after one wait");
	idle_nowait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("wait raised with no request");
	cfg_zero_a: assert property (rd_ok && avs_address == 5'h00 |-> (avs_readdata & 32'hFFFCFD1F) == 32'h0)
		else $error("reserved config bits not zero");
	unmapped_zero_a: assert property (rd_ok && !(avs_address inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10})
		|-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	step_gap_a: assert property (count_step |=> !count_step)
		else $error("count step longer than one cycle");
	flag_pulse_a: assert property ($rose(overflow_flag) |-> ##[0:2] overflow_pulse)
		else $error("flag set without overflow pulse");
	pulse_once_a: assert property (overflow_pulse |=> !overflow_pulse)
		else $error("overflow pulse too long");
	flag_stick_a: assert property (overflow_flag && !(wr_ok && avs_address == 5'h04
		&& avs_byteenable[0] && avs_writedata[7]) |=> overflow_flag)
		else $error("overflow flag dropped without clear");
	off_still_a: assert property (cs_q == 2'h0 && since_q > 4'h7 |-> !count_step)
		else $error("count step while disabled");
	pause_still_a: assert property (pause_q > 4'h7 |-> !count_step)
		else $error("count step while paused");
	gtb_follow_a: assert property (gtb_q && since_q > 4'h3
		|-> channel_timebase == $past(global_timebase_in))
		else $error("timebase not following global input");
endmodule

bind tcc_timer tcc_timer_checker u_chk (
	.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.counter_clock_pin(counter_clock_pin), .ext_clock_pin(ext_clock_pin),
	.trigger_pin(trigger_pin), .debug_mode_pin(debug_mode_pin), .doze_mode_pin(doze_mode_pin),
	.global_timebase_in(global_timebase_in), .channel_timebase(channel_timebase),
	.count_step(count_step), .overflow_flag(overflow_flag), .overflow_pulse(overflow_pulse)
);

// ==== testbench/tb_top.sv ====
// self-checking bench for the timer block: registers, modes, overflow.
// assumes the one-wait-cycle bus and three-clock pin latency of the design.
`timescale 1ns/1ps

module tb_top import tcc_pkg::*; ;
	// register rows: optional write, then a read compared with x
	typedef struct {
		logic we;
		logic [4:0] a;
		logic [3:0] be;
		logic [31:0] d;
		logic [31:0] x;
	} tcc_reg_row_t;
	// counting rows: config, control, pins, trigger, ticks, final count
	typedef struct {
		logic [31:0] cfg;
		logic [7:0] sc;
		logic dbg;
		logic doze;
		logic tr;
		int n;
		logic [15:0] x;
	} tcc_run_row_t;
	tcc_reg_row_t regs [15] = '{
		'{0, 5'h00, 4'hF, 32'h0, 32'h0}, '{0, 5'h04, 4'hF, 32'h0, 32'h0},
		'{0, 5'h08, 4'hF, 32'h0, 32'hFFFF}, '{0, 5'h0C, 4'hF, 32'h0, 32'h0},
		'{0, 5'h10, 4'hF, 32'h0, 32'h0}, '{0, 5'h14, 4'hF, 32'h0, 32'h0},
		'{0, 5'h02, 4'hF, 32'h0, 32'h0},
		'{1, 5'h00, 4'hF, 32'hFFFFFFFF, 32'h000302E0}, '{1, 5'h00, 4'h1, 32'h0, 32'h00030200},
		'{1, 5'h00, 4'hF, 32'h0, 32'h0}, '{1, 5'h08, 4'hF, 32'h1234ABCD, 32'hABCD},
		'{1, 5'h14, 4'hF, 32'hFFFFFFFF, 32'h0}, '{1, 5'h04, 4'hF, 32'hF, 32'hF},
		'{1, 5'h04, 4'hF, 32'h0, 32'h0}, '{1, 5'h0C, 4'hF, 32'h5, 32'h0}};
	// external clock first, so no edge is left latched from other rows
	tcc_run_row_t runs [9] = '{
		'{32'h0, 8'h10, 0, 0, 0, 16, 16'h4}, '{32'h0, 8'h08, 0, 0, 0, 4, 16'h4},
		'{32'h0, 8'h08, 1, 0, 0, 4, 16'h0}, '{32'hC0, 8'h08, 1, 0, 0, 4, 16'h4},
		'{32'h20, 8'h08, 0, 1, 0, 4, 16'h0}, '{32'h0, 8'h08, 0, 1, 0, 4, 16'h4},
		'{32'h10000, 8'h08, 0, 0, 0, 3, 16'h0}, '{32'h10000, 8'h08, 0, 0, 1, 3, 16'h3},
		'{32'h10000, 8'h08, 1, 0, 1, 3, 16'h0}};
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic counter_clock_pin = 1'b0;
	logic ext_clock_pin = 1'b0;
	logic trigger_pin = 1'b0;
	logic debug_mode_pin = 1'b0;
	logic doze_mode_pin = 1'b0;
	logic [15:0] global_timebase_in = 16'h0;
	logic [31:0] avs_readdata, v;
	logic avs_waitrequest, count_step, overflow_flag, overflow_pulse;
	logic [15:0] channel_timebase;
	int err_count = 0;
	int n_checks = 0;

	tcc_timer u_dut (
		.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.counter_clock_pin(counter_clock_pin), .ext_clock_pin(ext_clock_pin),
		.trigger_pin(trigger_pin), .debug_mode_pin(debug_mode_pin), .doze_mode_pin(doze_mode_pin),
		.global_timebase_in(global_timebase_in), .channel_timebase(channel_timebase),
		.count_step(count_step), .overflow_flag(overflow_flag), .overflow_pulse(overflow_pulse));

	// 250 MHz clock
	initial
	begin
		forever #2 clock = ~clock;
	end

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one bus transfer, held until wait drops; read data lands in v
	task automatic bus(input logic we, input logic [4:0] a, input logic [3:0] be,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_byteenable <= be;
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= !we;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		v = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 50)
			chk(32'h1, 32'h0);
		// gap lets settings pass the synchronisers before the next access
		repeat (2) @(posedge clock);
	endtask

	task automatic rc(input logic [4:0] a, input logic [31:0] x);
		bus(1'b0, a, 4'hF, 32'h0);
		chk(v, x);
	endtask

	// counter clock ticks; external clock rises on every fourth tick
	task automatic ticks(input int n);
		for (int i = 0; i < n; i++)
		begin
			counter_clock_pin <= 1'b1;
			ext_clock_pin <= i[1];
			repeat (2) @(posedge clock);
			counter_clock_pin <= 1'b0;
			repeat (2) @(posedge clock);
		end
		repeat (6) @(posedge clock);
	endtask

	task automatic pulse();
		trigger_pin <= 1'b1;
		repeat (4) @(posedge clock);
		trigger_pin <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	// disable, clear, configure, enable, tick, then read the count
	task automatic run(input tcc_run_row_t r);
		bus(1'b1, 5'h04, 4'hF, 32'h0);
		bus(1'b1, 5'h0C, 4'hF, 32'h0);
		bus(1'b1, 5'h00, 4'hF, r.cfg);
		debug_mode_pin <= r.dbg;
		doze_mode_pin <= r.doze;
		bus(1'b1, 5'h04, 4'hF, {24'h0, r.sc});
		if (r.tr)
		begin
			pulse();
			debug_mode_pin <= 1'b0;
			doze_mode_pin <= 1'b0;
			repeat (4) @(posedge clock);
		end
		ticks(r.n);
		rc(5'h0C, {16'h0, r.x});
		debug_mode_pin <= 1'b0;
		doze_mode_pin <= 1'b0;
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// watchdog, well beyond the roughly 5000 cycles the tests need
	initial
	begin
		repeat (40000) @(posedge clock);
		err_count++;
		final_report();
	end

	// main sequence
	initial
	begin
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		foreach (regs[i])
		begin
			if (regs[i].we)
				bus(1'b1, regs[i].a, regs[i].be, regs[i].d);
			rc(regs[i].a, regs[i].x);
		end
		$display("register test done");
		foreach (runs[i])
			run(runs[i]);
		for (int p = 0; p < 8; p++)
			run('{32'h0, 8'h08 | 8'(p), 1'b0, 1'b0, 1'b0, (4 << p) - 1, 16'h3});
		$display("mode test done");
		// stop on overflow with start on trigger, modulo 3
		bus(1'b1, 5'h08, 4'hF, 32'h3);
		run('{32'h30000, 8'h08, 1'b0, 1'b0, 1'b0, 6, 16'h0});
		rc(5'h10, 32'h1);
		pulse();
		ticks(6);
		rc(5'h0C, 32'h0);
		rc(5'h04, 32'h88);
		rc(5'h10, 32'h2);
		pulse();
		ticks(2);
		rc(5'h0C, 32'h2);
		bus(1'b1, 5'h04, 4'h1, 32'h88);
		rc(5'h04, 32'h8);
		bus(1'b1, 5'h04, 4'hF, 32'h0);
		rc(5'h04, 32'h0);
		rc(5'h0C, 32'h2);
		$display("overflow test done");
		global_timebase_in <= 16'hA5C3;
		bus(1'b1, 5'h00, 4'hF, 32'h200);
		repeat (2) @(posedge clock);
		chk({16'h0, channel_timebase}, 32'hA5C3);
		bus(1'b1, 5'h00, 4'hF, 32'h0);
		repeat (2) @(posedge clock);
		chk({16'h0, channel_timebase}, 32'h2);
		$display("timebase test done");
		// second reset while enabled
		bus(1'b1, 5'h04, 4'hF, 32'h8);
		nrst <= 1'b0;
		repeat (3) @(posedge clock);
		chk({13'h0, count_step, overflow_flag, overflow_pulse, channel_timebase}, 32'h0);
		nrst <= 1'b1;
		@(posedge clock);
		rc(5'h04, 32'h0);
		rc(5'h08, 32'hFFFF);
		$display("reset test done");
		final_report();
	end
endmodule
